//--- core/pwsc_sync_chain.sv
// PWM time base with sync chain and AXI4-Lite register slave
//
// What this block does
// - With phase loading on, an incoming sync strobe loads the counter from the phase register.
// - With phase loading off, an incoming sync strobe is ignored and counting goes on.
// - In flow-through selection the outgoing strobe follows the incoming strobe.
// - In period selection a strobe goes out when the counter equals the period value.
// - In compare-B selection a strobe goes out when the counter equals the second compare value.
// - In standalone selection no outgoing strobe is ever sent.
// - Phase-load enable and outgoing source are separate, freely combined fields.
// - Counting up, one PWM period lasts the period value plus one counts.
// - A slave at an integer multiple of the master frequency stays locked by the strobe.
// - Two outputs share one time base for two converter stages.
// - The counter runs from its own registers; only the sync strobe input comes from other modules.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pwsc_params.svh"

module pwsc_sync_chain (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire pwsc_pkg::pwsc_sync_t sync_strobe_input,
	output pwsc_pkg::pwsc_sync_t sync_strobe_output,
	output pwsc_pkg::pwsc_pwm_t pwm_out
);
	import pwsc_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic run_r;
	logic phase_load_enable_r;
	pwsc_sosel_t sync_output_select_r;
	logic [15:0] period_register_r;
	logic [15:0] phase_register_r;
	logic [15:0] comp1_r;
	logic [15:0] second_compare_value_r;
	logic [15:0] time_base_counter_r;
	logic [15:0] time_base_counter_nxt;
	logic sw_sync_r;
	logic sync_out_r;
	logic sync_seen_r;
	pwsc_pwm_t pwm_r;

	// ----------------------------------------
	// Write and read channel state
	// ----------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic awready_r;
	logic wready_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// Handshake decode
	wire aw_take = s_axi_awvalid && !aw_held_r && !bvalid_r;
	wire w_take = s_axi_wvalid && !w_held_r && !bvalid_r;
	wire wr_go = aw_held_r && w_held_r && !bvalid_r;
	wire aw_held_nxt = !wr_go && (aw_held_r || aw_take);
	wire w_held_nxt = !wr_go && (w_held_r || w_take);
	wire bvalid_nxt = wr_go || (bvalid_r && !s_axi_bready);
	wire ar_take = s_axi_arvalid && arready_r && !rvalid_r;
	wire wr_ctrl = wr_go && (aw_addr_r == `PWSC_OFF_CTRL);
	wire wr_period = wr_go && (aw_addr_r == `PWSC_OFF_PERIOD);
	wire wr_phs = wr_go && (aw_addr_r == `PWSC_OFF_PHASE);
	wire wr_comp1 = wr_go && (aw_addr_r == `PWSC_OFF_COMP1);
	wire wr_comp2 = wr_go && (aw_addr_r == `PWSC_OFF_COMP2);
	wire wr_stat = wr_go && (aw_addr_r == `PWSC_OFF_STATUS);
	wire wr_hit = wr_ctrl || wr_period || wr_phs || wr_comp1 || wr_comp2 || wr_stat;

	// Byte-lane merge of 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// Address and data capture, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `PWSC_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? `PWSC_RESP_OKAY : `PWSC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Channel readies, registered from the next holding state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
		end else begin
			awready_r <= !aw_held_nxt && !bvalid_nxt;
			wready_r <= !w_held_nxt && !bvalid_nxt;
		end
	end

	// Software-steered configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= 1'b0;
			phase_load_enable_r <= 1'b0;
			sync_output_select_r <= PWSC_SO_OFF;
			period_register_r <= `PWSC_RST_PERIOD;
			phase_register_r <= `PWSC_RST_PHASE;
			comp1_r <= `PWSC_RST_CMP;
			second_compare_value_r <= `PWSC_RST_CMP;
		end else begin
			if (wr_ctrl && w_strb_r[0]) begin
				run_r <= w_data_r[`PWSC_CTRL_RUN_BIT];
				phase_load_enable_r <= w_data_r[`PWSC_CTRL_PLOAD_BIT];
				sync_output_select_r <=
					pwsc_sosel_t'(w_data_r[`PWSC_CTRL_SOSEL_MSB:`PWSC_CTRL_SOSEL_LSB]);
			end
			if (wr_period)
				period_register_r <= merge16(period_register_r, w_data_r, w_strb_r);
			if (wr_phs)
				phase_register_r <= merge16(phase_register_r, w_data_r, w_strb_r);
			if (wr_comp1)
				comp1_r <= merge16(comp1_r, w_data_r, w_strb_r);
			if (wr_comp2)
				second_compare_value_r <= merge16(second_compare_value_r, w_data_r, w_strb_r);
		end
	end

	// Software sync pulse, one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sw_sync_r <= 1'b0;
		else
			sw_sync_r <= wr_ctrl && w_strb_r[0] && w_data_r[`PWSC_CTRL_SWSYNC_BIT];
	end

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	wire sync_arrive = sync_strobe_input.strobe || sw_sync_r;
	wire at_period = (time_base_counter_r == period_register_r);
	wire at_comp2 = (time_base_counter_r == second_compare_value_r);
	// load on sync, ignore when disabled, slave lock
	wire do_load = sync_arrive && phase_load_enable_r;

	// Next count: wraps after period, so period plus one counts
	always_comb begin
		time_base_counter_nxt = time_base_counter_r;
		if (do_load)
			time_base_counter_nxt = phase_register_r;
		else if (run_r)
			time_base_counter_nxt = at_period ? 16'h0000 : time_base_counter_r + 16'h0001;
	end

	// Counter register; runs standalone from its own registers
	always_ff @(posedge aclk) begin
		if (!aresetn)
			time_base_counter_r <= 16'h0000;
		else
			time_base_counter_r <= time_base_counter_nxt;
	end

	// ----------------------------------------
	// Outgoing sync select
	// ----------------------------------------
	logic so_event;
	always_comb begin
		case (sync_output_select_r)
			PWSC_SO_FLOW: so_event = sync_strobe_input.strobe;
			PWSC_SO_PERIOD: so_event = run_r && at_period;
			PWSC_SO_COMP2: so_event = run_r && at_comp2;
			PWSC_SO_OFF: so_event = 1'b0;
			default: so_event = 1'b0;
		endcase
	end

	// single-cycle strobe except in flow-through; slave locks on every master strobe
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sync_out_r <= 1'b0;
		else
			sync_out_r <= so_event && !(sync_out_r && sync_output_select_r != PWSC_SO_FLOW);
	end

	// Sticky sync-seen flag, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sync_seen_r <= 1'b0;
		else if (sync_strobe_input.strobe)
			sync_seen_r <= 1'b1;
		else if (wr_stat && w_strb_r[0] && w_data_r[0])
			sync_seen_r <= 1'b0;
	end

	// ----------------------------------------
	// Two outputs on one time base
	// ----------------------------------------
	// A and B high while counter below their compares
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pwm_r <= '0;
		else begin
			pwm_r.out_a <= run_r && (time_base_counter_nxt < comp1_r);
			pwm_r.out_b <= run_r && (time_base_counter_nxt < second_compare_value_r);
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`PWSC_OFF_CTRL: rd_mux = {28'h0, sync_output_select_r, phase_load_enable_r, run_r};
			`PWSC_OFF_PERIOD: rd_mux = {16'h0, period_register_r};
			`PWSC_OFF_PHASE: rd_mux = {16'h0, phase_register_r};
			`PWSC_OFF_COMP1: rd_mux = {16'h0, comp1_r};
			`PWSC_OFF_COMP2: rd_mux = {16'h0, second_compare_value_r};
			`PWSC_OFF_STATUS: rd_mux = {time_base_counter_r, 15'h0, sync_seen_r};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read answer one cycle after address taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `PWSC_RESP_OKAY;
		end else if (ar_take) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_hit ? `PWSC_RESP_OKAY : `PWSC_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Output drive
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign sync_strobe_output.strobe = sync_out_r;
	assign pwm_out = pwm_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// phase load from the pin
	pin_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_strobe_input.strobe && phase_load_enable_r) |=>
		(time_base_counter_r == $past(phase_register_r)))
		else $error("phase not loaded on sync");
	phase_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_load |=> time_base_counter_r == $past(phase_register_r))
		else $error("phase load missed");
	ignore_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_strobe_input.strobe && !phase_load_enable_r && run_r && !at_period) |=>
		time_base_counter_r == $past(time_base_counter_r) + 16'h0001)
		else $error("counter disturbed by ignored sync");
	flow_through_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_output_select_r == PWSC_SO_FLOW && sync_strobe_input.strobe &&
		!sync_out_r) |=> sync_strobe_output.strobe)
		else $error("flow-through strobe lost");
	period_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_output_select_r == PWSC_SO_PERIOD && run_r && at_period && !sync_out_r)
		|=> sync_strobe_output.strobe)
		else $error("period sync missing");
	comp2_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_output_select_r == PWSC_SO_COMP2 && run_r && at_comp2 && !sync_out_r)
		|=> sync_strobe_output.strobe)
		else $error("compare-B sync missing");
	standalone_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sync_output_select_r == PWSC_SO_OFF ##1 sync_output_select_r == PWSC_SO_OFF
		|-> !sync_strobe_output.strobe)
		else $error("strobe sent in standalone");
	period_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(run_r && at_period && !do_load) |=> time_base_counter_r == 16'h0000)
		else $error("counter did not wrap at period");
	single_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_strobe_output.strobe && sync_output_select_r != PWSC_SO_FLOW &&
		$stable(sync_output_select_r)) |=> !sync_strobe_output.strobe)
		else $error("sync strobe wider than one cycle");
	count_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(run_r && !at_period && !do_load) |=> time_base_counter_r ==
		$past(time_base_counter_r) + 16'h0001)
		else $error("counter did not advance");

	cover property (@(posedge aclk) disable iff (!aresetn) do_load);
	cover property (@(posedge aclk) disable iff (!aresetn)
		sync_output_select_r == PWSC_SO_PERIOD && sync_strobe_output.strobe);
	cover property (@(posedge aclk) disable iff (!aresetn)
		sync_output_select_r == PWSC_SO_COMP2 && sync_strobe_output.strobe);
	cover property (@(posedge aclk) disable iff (!aresetn)
		sync_output_select_r == PWSC_SO_FLOW && sync_strobe_output.strobe);

endmodule : pwsc_sync_chain

//--- pkg/pwsc_params.svh
// Offsets, field positions, reset values, counter width and bus answers of the sync chain
`ifndef PWSC_PARAMS_SVH
`define PWSC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PWSC_OFF_CTRL 8'h00
`define PWSC_OFF_PERIOD 8'h04
`define PWSC_OFF_PHASE 8'h08
`define PWSC_OFF_COMP1 8'h0c
`define PWSC_OFF_COMP2 8'h10
`define PWSC_OFF_STATUS 8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PWSC_CTRL_RUN_BIT 0
`define PWSC_CTRL_PLOAD_BIT 1
`define PWSC_CTRL_SOSEL_LSB 2
`define PWSC_CTRL_SOSEL_MSB 3
`define PWSC_CTRL_SWSYNC_BIT 4

// ----------------------------------------
// Reset values and counter width
// ----------------------------------------
`define PWSC_RST_PERIOD 16'hffff
`define PWSC_RST_PHASE 16'h0000
`define PWSC_RST_CMP 16'h0000
`define PWSC_CNT_W 16

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define PWSC_RESP_OKAY 2'b00
`define PWSC_RESP_SLVERR 2'b10

`endif

//--- pkg/pwsc_pkg.sv
// Types shared by the sync chain block
package pwsc_pkg;

	// Source of the outgoing sync strobe
	typedef enum logic [1:0] {
		PWSC_SO_FLOW = 2'b00,
		PWSC_SO_PERIOD = 2'b01,
		PWSC_SO_COMP2 = 2'b10,
		PWSC_SO_OFF = 2'b11
	} pwsc_sosel_t;

	// Write handshake state of the bus slave
	typedef enum logic [1:0] {
		PWSC_WR_IDLE = 2'b00,
		PWSC_WR_RESP = 2'b01
	} pwsc_wr_state_t;

	// Sync strobe pin, carried as a struct
	typedef struct packed {
		logic strobe;
	} pwsc_sync_t;

	// Two waveform outputs sharing one time base
	typedef struct packed {
		logic out_b;
		logic out_a;
	} pwsc_pwm_t;

endpackage : pwsc_pkg

//--- test/pwsc_sync_chain_tb.sv
// Self-checking bench for the sync chain time base
`timescale 1ns/100ps

module pwsc_sync_chain_tb;
	import pwsc_pkg::*;

	logic aclk = 0, aresetn = 0, fire = 0, per_en = 0;
	logic [7:0] per_len = 8'h00, awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	pwsc_sync_t up_sync, sync_strobe_output;
	pwsc_pwm_t pwm_out;
	int n_fail = 0, cmp_count = 0;

	// Clock generator, 100 ns period
	always #50 aclk = ~aclk;

	pwsc_upstream_model up (.aclk(aclk), .aresetn(aresetn), .fire(fire), .per_en(per_en),
		.per_len(per_len), .sync_o(up_sync));

	pwsc_sync_chain DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sync_strobe_input(up_sync),
		.sync_strobe_output(sync_strobe_output), .pwm_out(pwm_out));

	task print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task tmo;
		n_fail++;
		$display("unexpected at %0t: wait ran out", $time);
		print_verdict;
	endtask : tmo

	// Waits for the next upstream strobe, at most lim edges
	task up_wait(input int lim);
		int k;
		for (k = 0; k < lim; k++) begin
			@(posedge aclk);
			if (up_sync.strobe === 1'b1) break;
		end
		if (k == lim) tmo;
	endtask : up_wait

	// Bus write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w;
		int k;
		aw = 1;
		w = 1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (bvalid === 1'b1 && !aw && !w) break;
			if (aw && awready === 1'b1) begin
				awvalid <= 0;
				aw = 0;
			end
			if (w && wready === 1'b1) begin
				wvalid <= 0;
				w = 0;
			end
		end
		if (k == 50) tmo;
		r = bresp;
		bready <= 0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar;
		int k;
		ar = 1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (rvalid === 1'b1 && !ar) break;
			if (ar && arready === 1'b1) begin
				arvalid <= 0;
				ar = 0;
			end
		end
		if (k == 50) tmo;
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask : rd

	task wq(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, 32'h0, "write answer");
	endtask : wq

	// One strobe from the upstream neighbour
	task pin;
		@(posedge aclk);
		fire <= 1;
		@(posedge aclk);
		fire <= 0;
	endtask : pin

	// Edges until the outgoing strobe is seen, -1 if never; then its width
	task gap(input int lim, output int c);
		c = -1;
		for (int k = 1; k <= lim; k++) begin
			@(posedge aclk);
			if (sync_strobe_output.strobe === 1'b1) begin
				c = k;
				break;
			end
		end
		if (c > 0) begin
			@(posedge aclk);
			chk({31'h0, sync_strobe_output.strobe}, 32'h0, "strobe width");
		end
	endtask : gap

	task t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rd(8'h00, d, r);
		chk(d, 32'h0000_000c, "ctrl reset");
		rd(8'h04, d, r);
		chk(d, 32'h0000ffff, "period reset");
		rd(8'h1c, d, r);
		chk({30'h0, r}, 32'h2, "unmapped read");
		wr(8'h1c, 32'h1, r);
		chk({30'h0, r}, 32'h2, "unmapped write");
	endtask : t_reset

	task t_ignore_load;
		int c;
		logic [31:0] d;
		logic [1:0] r;
		wq(8'h04, 32'hc8);
		wq(8'h10, 32'h98);
		wq(8'h08, 32'h96);
		wq(8'h00, 32'h09);
		pin;
		gap(40, c);
		chk(c, -1, "strobe ignored");
		wq(8'h00, 32'h0b);
		pin;
		gap(10, c);
		chk(c > 0 && c < 9, 1, "phase loaded");
		wq(8'h00, 32'h12);
		rd(8'h14, d, r);
		chk(d, 32'h0096_0001, "software load and seen flag");
		wq(8'h14, 32'h1);
		rd(8'h14, d, r);
		chk(d, 32'h0096_0000, "seen flag cleared");
	endtask : t_ignore_load

	task t_flow_off;
		int c;
		wq(8'h00, 32'h01);
		pin;
		gap(5, c);
		chk(c > 0 && c < 5, 1, "flow-through");
		wq(8'h08, 32'h0);
		wq(8'h04, 32'h5);
		wq(8'h00, 32'h0f);
		pin;
		gap(40, c);
		chk(c, -1, "standalone");
	endtask : t_flow_off

	task t_master;
		int c;
		wq(8'h00, 32'h07);
		per_len <= 8'd11;
		per_en <= 1;
		repeat (14) @(posedge aclk);
		gap(20, c);
		for (int i = 0; i < 4; i++) begin
			gap(10, c);
			chk(c, 5, "period spacing");
		end
		wq(8'h08, 32'h3);
		up_wait(20);
		up_wait(20);
		gap(10, c);
		chk(c, 4, "lock offset");
		per_en <= 0;
		wq(8'h10, 32'h3);
		wq(8'h00, 32'h0b);
		gap(20, c);
		gap(10, c);
		chk(c, 5, "compare b spacing");
	endtask : t_master

	task t_pwm;
		int na, nb;
		na = 0;
		nb = 0;
		wq(8'h0c, 32'h2);
		wq(8'h10, 32'h4);
		repeat (6) @(posedge aclk);
		repeat (12) begin
			@(posedge aclk);
			na += (pwm_out.out_a === 1'b1);
			nb += (pwm_out.out_b === 1'b1);
		end
		chk(na, 4, "output a duty");
		chk(nb, 8, "output b duty");
	endtask : t_pwm

	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_ignore_load;
		t_flow_off;
		t_master;
		t_pwm;
		print_verdict;
	end
endmodule : pwsc_sync_chain_tb

//--- test/pwsc_upstream_model.sv
// Upstream neighbour module that sends sync strobes down the chain
`timescale 1ns/100ps

module pwsc_upstream_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fire,
	input wire logic per_en,
	input wire logic [7:0] per_len,
	output pwsc_pkg::pwsc_sync_t sync_o
);
	import pwsc_pkg::*;

	logic [7:0] cnt_r;

	// one-cycle strobe, from a demand or at the end of the master period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 8'h00;
			sync_o <= '0;
		end else begin
			cnt_r <= (per_en && cnt_r != per_len) ? cnt_r + 8'h01 : 8'h00;
			sync_o.strobe <= fire | (per_en && cnt_r == per_len);
		end
	end
endmodule : pwsc_upstream_model
